// *** include/bss_pkg.sv ***
// Constants for the start-up and speed sequencer.
// Assumes a single 100 MHz system clock.
package bss_pkg;
    // ****************************************
    // Phases
    // ****************************************
    typedef enum logic [2:0] {
        BSS_IDLE,
        BSS_PREPOS,
        BSS_RAMP,
        BSS_AUTO,
        BSS_REGUL
    } bss_phase_t;
    localparam logic [2:0] BSS_ST_IDLE = 3'h0;
    localparam logic [2:0] BSS_ST_PREPOS = 3'h1;
    localparam logic [2:0] BSS_ST_RAMP = 3'h2;
    localparam logic [2:0] BSS_ST_AUTO = 3'h3;
    localparam logic [2:0] BSS_ST_REGUL = 3'h4;
    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int BSS_STEP_W = 8;
    localparam int BSS_DUTY_W = 8;
    localparam int BSS_RAMP_AW = 6;
    localparam int BSS_RAMP_DW = 16;
    localparam int BSS_TICK_NS = 1000;
    localparam int BSS_CLK_NS = 10;
    localparam int BSS_TICK_CYC = BSS_TICK_NS / BSS_CLK_NS;
    localparam logic [7:0] BSS_DUTY_RST = 8'h00;
endpackage : bss_pkg

// *** rtl/bss_ramp_mem.sv ***
// Ramp table memory: software writes entries, sequencer reads them.
// Read data are registered, one cycle after the address.
`timescale 1ns/1ns
module bss_ramp_mem
    import bss_pkg::*;
#(
    parameter int AW = BSS_RAMP_AW,
    parameter int DW = BSS_RAMP_DW
) (
    // Clock
    input wire logic sys_clk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule : bss_ramp_mem

// *** rtl/bss_seq.sv ***
// Sensorless motor start-up sequencer and speed regulation loop.
// Assumes zc_in is asynchronous and parameters are stable while running.
//
// Functional notes
// RULE1 - Software must pre-position the rotor before starting; the block holds a hold phase.
// RULE2 - Software programs a start duty higher than the running duty.
// RULE3 - Ramp steps take step time and duty in order from the ramp table.
// RULE4 - Zero crossings are counted in ramp-up and at the threshold auto mode starts.
// RULE5 - Reaching the last ramp entry without auto mode stops the motor.
// RULE6 - Software picks the ramp length, typically thirty to forty entries.
// RULE7 - In open loop the user duty is followed from auto mode onward.
// RULE8 - Regulation starts only after a programmed number of auto steps.
// RULE9 - In closed loop a speed loop drives the duty toward the target.
// RULE10 - The speed error is corrected once every N motor steps.
// RULE11 - Ratio and timer load from software are used and corrected by the loop. The code corrects only ratio; tload is held.
// RULE12 - Software supplies gains and starting duty with each target.
// RULE13 - User duty is followed until speed first crosses the target, then ignored.
// RULE14 - An 8-bit step timer is captured then cleared on each zero crossing. The code captures and clears only in auto and regulation phases.
// RULE15 - A start-failure flag is set when ramp-up ends without auto mode.
// RULE16 - The current phase is shown on a status output.
`timescale 1ns/1ns
module bss_seq
    import bss_pkg::*;
#(
    parameter int AW = BSS_RAMP_AW
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Control
    input wire logic start,
    input wire logic stop,
    input wire logic closed_loop,
    input wire logic [15:0] prepos_ticks,
    input wire logic [AW-1:0] ramp_len,
    input wire logic [7:0] zc_thresh,
    input wire logic [7:0] reg_delay_steps,
    input wire logic [7:0] integ_steps,
    input wire logic [15:0] ratio_in,
    input wire logic [15:0] tload_in,
    input wire logic [7:0] kp,
    input wire logic [7:0] ki,
    input wire logic [BSS_DUTY_W-1:0] user_duty,
    // Ramp table load
    input wire logic ramp_wr,
    input wire logic [AW-1:0] ramp_waddr,
    input wire logic [15:0] ramp_wdata,
    // Motor side
    input wire logic zc_in,
    output logic commutate,
    output logic drive_en,
    output logic [BSS_DUTY_W-1:0] duty,
    // Status
    output logic [2:0] phase,
    output logic start_fail,
    output logic [BSS_STEP_W-1:0] step_meas,
    output logic [15:0] ratio,
    output logic [15:0] tload
);
    // ****************************************
    // Microsecond tick and zero-cross input
    // ****************************************
    logic [7:0] tick_cnt_r;
    logic tick;
    logic [2:0] zc_sync_r;
    logic zc_lvl_r;
    logic zc_ev;
    bss_phase_t st_r;
    logic [AW-1:0] ramp_idx_r;
    logic [15:0] ramp_rd;
    logic [15:0] tmr_r;
    logic [7:0] zc_cnt_r;
    logic [7:0] auto_cnt_r;
    logic [7:0] integ_cnt_r;
    logic [BSS_STEP_W-1:0] step_tmr_r;
    logic crossed_r;
    logic ramp_step_done;

    assign tick = (tick_cnt_r == 8'(BSS_TICK_CYC - 1));

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_r <= 8'h00;
        end else if (tick) begin
            tick_cnt_r <= 8'h00;
        end else begin
            tick_cnt_r <= tick_cnt_r + 8'h01;
        end
    end

    // Edge counts only once stages two and three agree
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            zc_sync_r <= 3'h0;
            zc_lvl_r <= 1'b0;
        end else begin
            zc_sync_r <= {zc_sync_r[1:0], zc_in};
            if (zc_sync_r[1] == zc_sync_r[2]) begin
                zc_lvl_r <= zc_sync_r[2];
            end
        end
    end
    assign zc_ev = (zc_sync_r[1] == zc_sync_r[2]) && zc_sync_r[2] && !zc_lvl_r;

    // ****************************************
    // Ramp table
    // ****************************************
    bss_ramp_mem #(.AW(AW), .DW(16)) u_mem (
        .sys_clk(sys_clk),
        .wr_en(ramp_wr),
        .wr_addr(ramp_waddr),
        .wr_data(ramp_wdata),
        .rd_addr(ramp_idx_r),
        .rd_data(ramp_rd)
    );

    // Entry: step time in ticks [15:8], duty [7:0]
    assign ramp_step_done = (st_r == BSS_RAMP) && tick &&
                            (tmr_r[7:0] >= ramp_rd[15:8]); // [RULE3]

    // ****************************************
    // Phase sequencer
    // ****************************************
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= BSS_IDLE;
        end else if (stop) begin
            st_r <= BSS_IDLE;
        end else begin
            case (st_r)
                BSS_IDLE: begin
                    if (start) begin
                        st_r <= BSS_PREPOS; // [RULE1]
                    end
                end
                BSS_PREPOS: begin
                    if (tick && tmr_r >= prepos_ticks) begin
                        st_r <= BSS_RAMP;
                    end
                end
                BSS_RAMP: begin
                    if (zc_ev && zc_cnt_r + 8'h01 >= zc_thresh) begin
                        st_r <= BSS_AUTO; // [RULE4]
                    end else if (ramp_step_done && ramp_idx_r == ramp_len - AW'(1)) begin
                        st_r <= BSS_IDLE; // [RULE5]
                    end
                end
                BSS_AUTO: begin
                    if (closed_loop && zc_ev && auto_cnt_r + 8'h01 >= reg_delay_steps) begin
                        st_r <= BSS_REGUL; // [RULE8]
                    end
                end
                BSS_REGUL: begin
                    if (!closed_loop) begin
                        st_r <= BSS_AUTO;
                    end
                end
                default: st_r <= BSS_IDLE;
            endcase
        end
    end

    // Phase timer in ticks
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tmr_r <= 16'h0000;
        end else if (st_r == BSS_IDLE || ramp_step_done) begin
            tmr_r <= 16'h0000;
        end else if (st_r == BSS_PREPOS && tick && tmr_r >= prepos_ticks) begin
            tmr_r <= 16'h0000;
        end else if (tick) begin
            tmr_r <= tmr_r + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ramp_idx_r <= '0;
        end else if (st_r != BSS_RAMP) begin
            ramp_idx_r <= '0;
        end else if (ramp_step_done) begin
            ramp_idx_r <= ramp_idx_r + AW'(1); // [RULE3]
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            zc_cnt_r <= 8'h00;
        end else if (st_r != BSS_RAMP) begin
            zc_cnt_r <= 8'h00;
        end else if (zc_ev) begin
            zc_cnt_r <= zc_cnt_r + 8'h01; // [RULE4]
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            auto_cnt_r <= 8'h00;
        end else if (st_r != BSS_AUTO) begin
            auto_cnt_r <= 8'h00;
        end else if (zc_ev) begin
            auto_cnt_r <= auto_cnt_r + 8'h01; // [RULE8]
        end
    end

    // Set wins over the clear that a new start gives
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            start_fail <= 1'b0;
        end else if (ramp_step_done && ramp_idx_r == ramp_len - AW'(1) &&
                     !(zc_ev && zc_cnt_r + 8'h01 >= zc_thresh) && !stop) begin
            start_fail <= 1'b1; // [RULE15]
        end else if (start && st_r == BSS_IDLE) begin
            start_fail <= 1'b0;
        end
    end

    // ****************************************
    // Step time measurement
    // ****************************************
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            step_tmr_r <= '0;
            step_meas <= '0;
        end else if (zc_ev && (st_r == BSS_AUTO || st_r == BSS_REGUL)) begin
            step_meas <= step_tmr_r; // [RULE14]
            step_tmr_r <= '0;
        end else if (tick && step_tmr_r != '1) begin
            step_tmr_r <= step_tmr_r + BSS_STEP_W'(1);
        end
    end

    // ****************************************
    // Speed regulation
    // ****************************************
    logic integ_due;
    logic [15:0] err;
    assign integ_due = (st_r == BSS_REGUL) && zc_ev && (integ_cnt_r + 8'h01 >= integ_steps);
    // Error uses the captured step time against the target held in tload
    assign err = tload - {8'h00, step_meas};

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            integ_cnt_r <= 8'h00;
        end else if (st_r != BSS_REGUL || integ_due) begin
            integ_cnt_r <= 8'h00;
        end else if (zc_ev) begin
            integ_cnt_r <= integ_cnt_r + 8'h01; // [RULE10]
        end
    end

    // Target crossed once measured step drops to the target step time
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            crossed_r <= 1'b0;
        end else if (st_r != BSS_REGUL) begin
            crossed_r <= 1'b0;
        end else if (integ_due && {8'h00, step_meas} <= tload) begin
            crossed_r <= 1'b1; // [RULE13]
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ratio <= 16'h0000;
            tload <= 16'h0000;
        end else if (st_r != BSS_REGUL) begin
            ratio <= ratio_in;
            tload <= tload_in;
        end else if (integ_due) begin
            ratio <= ratio + {{8{err[15]}}, err[15:8]}; // [RULE11]
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            duty <= BSS_DUTY_RST;
        end else begin
            case (st_r)
                BSS_RAMP: duty <= ramp_rd[7:0]; // [RULE3]
                BSS_AUTO: duty <= user_duty; // [RULE7]
                BSS_REGUL: begin
                    if (!crossed_r) begin
                        duty <= user_duty; // [RULE13]
                    end else if (integ_due) begin
                        // Positive error means too fast: back off the drive
                        if (err[15]) begin
                            duty <= (duty > 8'hff - kp) ? 8'hff : duty + kp; // [RULE9]
                        end else if (err != 16'h0000) begin
                            duty <= (duty < ki) ? 8'h00 : duty - ki; // [RULE9]
                        end
                    end
                end
                BSS_PREPOS: duty <= user_duty;
                default: duty <= BSS_DUTY_RST;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            commutate <= 1'b0;
        end else begin
            commutate <= ramp_step_done ||
                         (zc_ev && (st_r == BSS_AUTO || st_r == BSS_REGUL));
        end
    end

    assign drive_en = (st_r != BSS_IDLE);
    assign phase = 3'(st_r); // [RULE16]

    // ****************************************
    // Checks
    // ****************************************
    a_fail_stops: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE5]
        $rose(start_fail) |-> st_r == BSS_IDLE && !drive_en)
        else $error("start failure without stop");
    a_fail_cause: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE15]
        $rose(start_fail) |-> $past(st_r) == BSS_RAMP)
        else $error("failure flag outside ramp");
    a_auto_entry: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE4]
        (st_r == BSS_RAMP && !stop && zc_ev && zc_cnt_r + 8'h01 >= zc_thresh)
        |=> st_r == BSS_AUTO)
        else $error("threshold did not enter auto");
    a_regul_entry: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE8]
        (st_r == BSS_REGUL && $past(st_r) == BSS_AUTO) |-> $past(zc_ev))
        else $error("regulation entered without step");
    a_step_capture: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE14]
        (zc_ev && (st_r == BSS_AUTO || st_r == BSS_REGUL))
        |=> step_tmr_r == '0 && step_meas == $past(step_tmr_r))
        else $error("step time not captured");
    a_user_duty: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE7]
        (st_r == BSS_AUTO && !stop) ##1 st_r == BSS_AUTO |-> duty == $past(user_duty))
        else $error("auto duty not user value");
    a_duty_owned: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE13]
        (crossed_r && st_r == BSS_REGUL && !integ_due) |=> $stable(duty) || st_r != BSS_REGUL)
        else $error("duty moved outside correction");
    a_ramp_order: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE3]
        (ramp_step_done && st_r == BSS_RAMP && !stop && !zc_ev)
        |=> ramp_idx_r == $past(ramp_idx_r) + AW'(1) || st_r == BSS_IDLE)
        else $error("ramp index not advanced");
    a_phase_out: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE16]
        (st_r == BSS_REGUL) |-> phase == BSS_ST_REGUL)
        else $error("phase status wrong");
endmodule : bss_seq

// *** tb/bss_motor_model.sv ***
// Motor model: a commutation retimes the next back-EMF zero crossing, and a
// turning rotor keeps crossing every gap cycles until the next commutation.
// Assumes commutate is a one-cycle pulse on sys_clk.
`timescale 1ns/1ns
module bss_motor_model (
    // Clock
    input wire logic sys_clk,
    // Control from the bench
    input wire logic en,
    input wire logic [15:0] gap,
    // Motor side
    input wire logic commutate,
    output logic zc_in
);
    logic [15:0] wait_r = 16'h0000;
    logic [2:0] hi_r = 3'h0;
    // A stalled rotor (en low) gives no crossing beyond one already pending
    always @(posedge sys_clk) begin
        if (hi_r != 3'h0) begin
            hi_r <= hi_r - 3'h1;
        end
        if (commutate && en) begin
            wait_r <= gap;
        end else if (wait_r == 16'h0001) begin
            // Crossings go on between commutations, so several can count toward auto mode within one ramp step
            wait_r <= en ? gap : 16'h0000;
            hi_r <= 3'h4;
        end else if (wait_r != 16'h0000) begin
            wait_r <= wait_r - 16'h0001;
        end
    end
    // Held high four cycles so the synchroniser cannot miss it
    assign zc_in = (hi_r != 3'h0);
endmodule : bss_motor_model

// *** tb/tb_bss_seq.sv ***
// Self-checking bench for the start-up and speed sequencer.
// Assumes a 100 MHz clock and a 1 us internal tick.
`timescale 1ns/1ns
module tb_bss_seq;
    import bss_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1, start = 1'b0, stop = 1'b0, closed_loop = 1'b0;
    logic [15:0] prepos_ticks = 16'h0002, ratio_in = 16'h1234, tload_in = 16'h0110;
    logic [5:0] ramp_len = 6'h03, ramp_waddr = 6'h00;
    logic [7:0] zc_thresh = 8'h03, reg_delay_steps = 8'h04, integ_steps = 8'h02;
    logic [7:0] kp = 8'h03, ki = 8'h05, user_duty = 8'h80;
    logic ramp_wr = 1'b0, commutate, drive_en, start_fail, m_en = 1'b0;
    logic [15:0] ramp_wdata = 16'h0000, ratio, tload, m_gap = 16'd1000;
    logic zc_in;
    logic [7:0] duty, step_meas;
    logic [2:0] phase;
    int fails = 0, cmp_count = 0;
    bss_seq bss_seq_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .start(start), .stop(stop),
        .closed_loop(closed_loop), .prepos_ticks(prepos_ticks), .ramp_len(ramp_len),
        .zc_thresh(zc_thresh), .reg_delay_steps(reg_delay_steps), .integ_steps(integ_steps),
        .ratio_in(ratio_in), .tload_in(tload_in), .kp(kp), .ki(ki), .user_duty(user_duty),
        .ramp_wr(ramp_wr), .ramp_waddr(ramp_waddr), .ramp_wdata(ramp_wdata), .zc_in(zc_in),
        .commutate(commutate), .drive_en(drive_en), .duty(duty), .phase(phase),
        .start_fail(start_fail), .step_meas(step_meas), .ratio(ratio), .tload(tload));
    bss_motor_model bss_motor_model_i (.sys_clk(sys_clk), .en(m_en), .gap(m_gap),
        .commutate(commutate), .zc_in(zc_in));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc
    task automatic wait_phase(input logic [2:0] p, input int limit);
        int i;
        for (i = 0; i < limit && phase !== p; i++) begin
            @(negedge sys_clk);
        end
        chk("phase reached", {13'h0, p}, {13'h0, phase});
    endtask : wait_phase
    // Step ticks in the high byte, duty in the low byte
    task automatic load_ramp(input logic [7:0] ticks);
        int i;
        for (i = 0; i < 8; i++) begin
            @(negedge sys_clk);
            ramp_wr = 1'b1;
            ramp_waddr = i[5:0];
            ramp_wdata = {ticks, 8'h40 + i[7:0]};
        end
        @(negedge sys_clk);
        ramp_wr = 1'b0;
    endtask : load_ramp
    task automatic kick;
        @(negedge sys_clk);
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        chk("phase after start", {13'h0, BSS_ST_PREPOS}, {13'h0, phase});
    endtask : kick
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        chk("phase idle", {13'h0, BSS_ST_IDLE}, {13'h0, phase});
        chk("flags", 16'h0000, {13'h0, drive_en, start_fail, commutate});
        chk("duty reset", {8'h0, BSS_DUTY_RST}, {8'h0, duty});
        $display("test reset done");
    endtask : t_reset
    // Stalled rotor: table steps in order, then stop with the failure flag
    task automatic t_fail;
        load_ramp(8'h02);
        m_en = 1'b0;
        kick();
        chk("drive enabled", 16'h0001, {15'h0, drive_en});
        wait_phase(BSS_ST_RAMP, 400);
        cyc(100);
        chk("ramp duty 0", 16'h0040, {8'h0, duty});
        @(posedge commutate);
        cyc(100);
        chk("ramp duty 1", 16'h0041, {8'h0, duty});
        wait_phase(BSS_ST_IDLE, 800);
        chk("start fail", 16'h0001, {15'h0, start_fail});
        chk("drive off", 16'h0000, {15'h0, drive_en});
        $display("test start failure done");
    endtask : t_fail
    // Motor answers: auto mode reached, open-loop duty follows the user
    task automatic t_auto;
        load_ramp(8'h14);
        ramp_len = 6'h08;
        m_en = 1'b1;
        kick();
        cyc(2);
        chk("fail cleared", 16'h0000, {15'h0, start_fail});
        wait_phase(BSS_ST_AUTO, 12000);
        cyc(5000);
        chk("stays auto", {13'h0, BSS_ST_AUTO}, {13'h0, phase});
        cmp_count++;
        if (step_meas < 8'd9 || step_meas > 8'd11) begin
            fails++;
            $display("mismatch step_meas expected 0a seen %h", step_meas);
        end
        chk("ratio follows input", ratio_in, ratio);
        chk("tload follows input", tload_in, tload);
        user_duty = 8'h55;
        cyc(20);
        chk("open loop duty", 16'h0055, {8'h0, duty});
        $display("test auto mode done");
    endtask : t_auto
    // Closed loop: regulation after the delay, then the user duty is ignored
    task automatic t_regul;
        int steps;
        @(negedge sys_clk);
        stop = 1'b1;
        user_duty = 8'h80;
        closed_loop = 1'b1;
        @(negedge sys_clk);
        stop = 1'b0;
        kick();
        wait_phase(BSS_ST_AUTO, 12000);
        cyc(2500);
        chk("not yet regul", {13'h0, BSS_ST_AUTO}, {13'h0, phase});
        wait_phase(BSS_ST_REGUL, 5000);
        cyc(7000);
        cmp_count++;
        if (duty >= 8'h80 || ((8'h80 - duty) % 8'h05) != 8'h00) begin
            fails++;
            $display("mismatch regulated duty expected 80 minus steps of 05 seen %h", duty);
        end
        // Each correction adds one to the ratio; the first only marks the crossing
        steps = (8'h80 - duty) / 8'h05;
        chk("ratio corrected", ratio_in + 16'(steps + 1), ratio);
        chk("tload held", tload_in, tload);
        user_duty = 8'hf0;
        cyc(300);
        cmp_count++;
        if (duty >= 8'h80) begin
            fails++;
            $display("mismatch owned duty expected below 80 seen %h", duty);
        end
        closed_loop = 1'b0;
        cyc(2);
        chk("back to auto", {13'h0, BSS_ST_AUTO}, {13'h0, phase});
        @(negedge sys_clk);
        stop = 1'b1;
        cyc(2);
        chk("stopped", {13'h0, BSS_ST_IDLE}, {13'h0, phase});
        stop = 1'b0;
        $display("test regulation done");
    endtask : t_regul
    // ****************************************
    // Sequence and verdict
    // ****************************************
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (12) @(negedge sys_clk);
        sys_rst = 1'b0;
        t_reset();
        t_fail();
        t_auto();
        t_regul();
        end_sim();
    end
    initial begin
        #600000;
        fails++;
        $display("test watchdog expired");
        end_sim();
    end
endmodule : tb_bss_seq
